// ---- src/sra_pkg.sv ----
// Shared types, layout and register table of the special register area
package sra_pkg;

  localparam int SRA_ADDR_W = 8;
  localparam int SRA_AREA_BYTES = 256;
  localparam logic [SRA_ADDR_W-1:0] SRA_AREA_BASE = 8'h00;
  localparam int SRA_BYTE_W = 8;
  localparam int SRA_WORD_W = 16;
  localparam int SRA_SLOTS = 8;
  localparam int SRA_IDX_W = 3;
  localparam logic [7:0] SRA_BYTE_ZERO = 8'h00;

  // Direction attribute of a register
  typedef enum logic [1:0] {
    SRA_DIR_RW,
    SRA_DIR_RO,
    SRA_DIR_WO
  } sra_dir_e;

  // Access width attribute of a register
  typedef enum logic [1:0] {
    SRA_WID_BOTH,
    SRA_WID_8,
    SRA_WID_16
  } sra_wid_e;

  // One byte slot of the area; masks mark bits of special kind
  typedef struct packed {
    logic [SRA_ADDR_W-1:0] addr;
    sra_dir_e dir;
    sra_wid_e wid;
    logic [7:0] init;
    logic [7:0] fix0;
    logic [7:0] fix1;
    logic [7:0] ign0;
    logic [7:0] ign1;
  } sra_desc_s;

  // CPU data memory request, one cycle
  typedef struct packed {
    logic valid;
    logic we;
    logic wide;
    logic [SRA_ADDR_W-1:0] addr;
    logic [SRA_WORD_W-1:0] wdata;
  } sra_req_s;

  // Answer, one cycle after the request
  typedef struct packed {
    logic ack;
    logic err;
    logic [SRA_WORD_W-1:0] rdata;
  } sra_rsp_s;

  // Initial-value load causes, all synchronous
  typedef struct packed {
    logic external_reset_input;
    logic break_instruction;
    logic wdt_overflow;
    logic opcode_trap;
  } sra_init_s;

  localparam sra_desc_s SRA_MAP [SRA_SLOTS] = '{
    '{8'h00, SRA_DIR_RW, SRA_WID_16, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'h01, SRA_DIR_RW, SRA_WID_16, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'h02, SRA_DIR_RW, SRA_WID_BOTH, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'h03, SRA_DIR_RW, SRA_WID_BOTH, 8'h00, 8'hf0, 8'h00, 8'h00, 8'h00},
    '{8'h10, SRA_DIR_RW, SRA_WID_8, 8'h8b, 8'h00, 8'h00, 8'h70, 8'h88},
    '{8'h11, SRA_DIR_WO, SRA_WID_8, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'h12, SRA_DIR_RO, SRA_WID_8, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'h13, SRA_DIR_RW, SRA_WID_8, 8'h0c, 8'h00, 8'h0c, 8'h00, 8'h00}
  };

endpackage : sra_pkg

// ---- src/sra_cell.sv ----
// One byte register of the special register area
`timescale 1ns/1ps
module sra_cell
  import sra_pkg::*;
#(
  parameter sra_desc_s DESC = SRA_MAP[0]
) (
  input wire logic i_sys_clk,  // System clock
  input wire logic i_load_init,  // Load initial value
  input wire logic i_we,  // Byte write strobe
  input wire logic [7:0] i_wdata,  // Write byte
  input wire logic [7:0] i_hw_value,  // Hardware value, read-only cells
  output logic [7:0] o_rd_value,  // Value seen by a read
  output logic [7:0] o_value  // Stored value to the peripheral
);
  import sra_pkg::*;

  typedef struct packed {
    logic [7:0] value;
  } sra_cell_s;

  localparam logic [7:0] CONST_MASK =
    DESC.fix0 | DESC.fix1 | DESC.ign0 | DESC.ign1;
  localparam logic [7:0] CONST_ONES = DESC.fix1 | DESC.ign1;

  sra_cell_s state_reg;
  sra_cell_s state_next;
  logic [7:0] src;

  // A bit cannot be held at both levels at once
  if ((DESC.fix0 & DESC.fix1) != SRA_BYTE_ZERO ||
      (DESC.ign0 & DESC.ign1) != SRA_BYTE_ZERO) begin : g_bad_desc
    $error("sra_cell: bit marked both constant zero and one");
  end

  always_comb begin
    state_next = state_reg;
    if (i_load_init) begin
      state_next.value = DESC.init;
    end else if (i_we) begin
      // Constant bits never take the written value
      state_next.value = (i_wdata & ~CONST_MASK) | CONST_ONES;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    state_reg <= state_next;
  end

  // Read-only cells show hardware state; constants override either source
  assign src = (DESC.dir == SRA_DIR_RO) ? i_hw_value : state_reg.value;
  assign o_rd_value = (src & ~CONST_MASK) | CONST_ONES;
  assign o_value = state_reg.value;

endmodule : sra_cell

// ---- src/sra_area.sv ----
// Special register area: decode, access checks and register bank
//
// How it works
// - 256 bytes from data address zero form the register area.
// - Each register answers only its listed units; others are refused.
// - Fixed-zero bits always read zero; software writes zero there.
// - Fixed-one bits always read one; software writes one there.
// - Ignore-write bits drop every write and read their set constant.
// - Access is read-write, read-only or write-only; misuse is refused.
// - Width attribute is 8/16, 8 only or 16 only; others refused.
// - Reset, break, watchdog overflow or opcode trap load init values.
// - A bit with two symbolic names is one physical bit.
`timescale 1ns/1ps
module sra_area
  import sra_pkg::*;
#(
  parameter int SLOTS = SRA_SLOTS
) (
  input wire logic i_sys_clk,  // System clock, 125 MHz
  input wire logic i_rst,  // Synchronous reset, active high
  input wire sra_pkg::sra_init_s i_init,  // Other initial-value causes
  input wire sra_pkg::sra_req_s i_req,  // CPU access request
  input wire logic [SLOTS-1:0][7:0] i_hw_value,  // Read-only sources
  output sra_pkg::sra_rsp_s o_rsp,  // CPU access answer
  output logic [SLOTS-1:0][7:0] o_value,  // Stored register bytes
  output logic [SLOTS-1:0] o_wr_pulse  // Per-byte write pulse
);
  import sra_pkg::*;

  typedef struct packed {
    sra_rsp_s rsp;
    logic [SLOTS-1:0] wr;
  } sra_area_s;

  sra_area_s state_reg;
  sra_area_s state_next;
  logic load_init;
  logic [SLOTS-1:0][7:0] rd_value;
  logic [SLOTS-1:0] cell_we;
  logic [SLOTS-1:0][7:0] cell_wdata;
  logic [SRA_ADDR_W-1:0] lo_addr;
  logic [SRA_ADDR_W-1:0] hi_addr;
  logic lo_hit;
  logic hi_hit;
  logic [SRA_IDX_W-1:0] lo_idx;
  logic [SRA_IDX_W-1:0] hi_idx;
  logic in_area;
  logic unit_ok;
  logic dir_ok;
  logic access_ok;

  // The bank is built from the table, so its size is not free to change
  if (SLOTS != SRA_SLOTS) begin : g_bad_slots
    $error("sra_area: SLOTS must match the register table");
  end
  // Slot indices must reach every table entry
  if ((1 << SRA_IDX_W) < SRA_SLOTS) begin : g_bad_idx
    $error("sra_area: slot index too narrow for the table");
  end
  // A word is exactly two bytes; the lane split relies on it
  if (SRA_WORD_W != 2 * SRA_BYTE_W) begin : g_bad_word
    $error("sra_area: word must be two bytes wide");
  end

  // Count of table slots that sit at one byte address
  function automatic int slots_at(input logic [SRA_ADDR_W-1:0] a);
    int n;
    n = 0;
    for (int k = 0; k < SRA_SLOTS; k++) begin
      if (SRA_MAP[k].addr == a) begin
        n++;
      end
    end
    return n;
  endfunction : slots_at

  // The table is fixed at build time, so a bad entry is refused here
  // instead of showing up later as a strange answer on the bus
  for (genvar t = 0; t < SRA_SLOTS; t++) begin : g_table_chk
    localparam sra_desc_s D = SRA_MAP[t];
    localparam logic [SRA_ADDR_W-1:0] PARTNER =
      {D.addr[SRA_ADDR_W-1:1], ~D.addr[0]};
    // Every slot must fall inside the decoded window
    if (32'(D.addr) - 32'(SRA_AREA_BASE) >=
        32'(SRA_AREA_BYTES)) begin : g_outside
      $error("sra_area: table slot lies outside the area");
    end
    // Two slots at one byte would both answer a single access
    if (slots_at(D.addr) != 1) begin : g_twice
      $error("sra_area: two table slots share one address");
    end
    // A word-only byte without its partner could never be reached
    if (D.wid == SRA_WID_16 && slots_at(PARTNER) != 1) begin : g_lone
      $error("sra_area: word-only slot lacks its partner byte");
    end
    // Initial values load raw, so they must already obey the constants
    if ((D.init & (D.fix0 | D.ign0)) != SRA_BYTE_ZERO ||
        (~D.init & (D.fix1 | D.ign1)) != SRA_BYTE_ZERO) begin : g_init
      $error("sra_area: initial value breaks a constant bit");
    end
  end

  assign load_init = i_rst | i_init.external_reset_input |
    i_init.break_instruction | i_init.wdt_overflow | i_init.opcode_trap;

  // Word accesses always pair an even byte with the odd one above it
  assign lo_addr = i_req.wide ? {i_req.addr[SRA_ADDR_W-1:1], 1'b0}
                              : i_req.addr;
  assign hi_addr = {lo_addr[SRA_ADDR_W-1:1], 1'b1};
  assign in_area = (32'(i_req.addr) - 32'(SRA_AREA_BASE)) <
                   SRA_AREA_BYTES;

  // Plain search over a small table; the build checks forbid two slots
  // at one address, so at most one entry can match each byte
  always_comb begin
    lo_hit = 1'b0;
    hi_hit = 1'b0;
    lo_idx = '0;
    hi_idx = '0;
    for (int i = 0; i < SLOTS; i++) begin
      if (SRA_MAP[i].addr == lo_addr) begin
        lo_hit = 1'b1;
        lo_idx = SRA_IDX_W'(i);
      end
      if (SRA_MAP[i].addr == hi_addr) begin
        hi_hit = 1'b1;
        hi_idx = SRA_IDX_W'(i);
      end
    end
  end

  always_comb begin
    unit_ok = 1'b0;
    dir_ok = 1'b0;
    if (i_req.wide) begin
      unit_ok = lo_hit && hi_hit &&
                SRA_MAP[lo_idx].wid != SRA_WID_8 &&
                SRA_MAP[hi_idx].wid != SRA_WID_8;
    end else begin
      unit_ok = lo_hit &&
                SRA_MAP[lo_idx].wid != SRA_WID_16;
    end
    if (i_req.we) begin
      dir_ok = SRA_MAP[lo_idx].dir != SRA_DIR_RO &&
               (!i_req.wide ||
                SRA_MAP[hi_idx].dir != SRA_DIR_RO);
    end else begin
      dir_ok = SRA_MAP[lo_idx].dir != SRA_DIR_WO &&
               (!i_req.wide ||
                SRA_MAP[hi_idx].dir != SRA_DIR_WO);
    end
  end

  assign access_ok = in_area && unit_ok && dir_ok;

  // A write in a load cycle is dropped; the initial value wins
  always_comb begin
    cell_we = '0;
    if (i_req.valid && i_req.we && access_ok && !load_init) begin
      cell_we[lo_idx] = 1'b1;
      if (i_req.wide) begin
        cell_we[hi_idx] = 1'b1;
      end
    end
  end

  // Each byte of a word goes to its own cell; a narrow write always uses
  // the low lane, whatever the parity of its address
  always_comb begin
    for (int i = 0; i < SLOTS; i++) begin
      cell_wdata[i] = i_req.wdata[SRA_BYTE_W-1:0];
      if (i_req.wide && SRA_IDX_W'(i) == hi_idx) begin
        cell_wdata[i] = i_req.wdata[SRA_WORD_W-1:SRA_BYTE_W];
      end
    end
  end

  // Each table byte is one physical cell, whatever names its bits carry
  for (genvar g = 0; g < SRA_SLOTS; g++) begin : g_cell
    sra_cell #(
      .DESC(SRA_MAP[g])
    ) u_cell (
      .i_sys_clk(i_sys_clk),
      .i_load_init(load_init),
      .i_we(cell_we[g]),
      .i_wdata(cell_wdata[g]),
      .i_hw_value(i_hw_value[g]),
      .o_rd_value(rd_value[g]),
      .o_value(o_value[g])
    );
  end

  // The answer is registered: ack and err stand one cycle after the taking
  // edge. A request in a load cycle is dropped without an answer, since
  // the cells are busy taking their initial values then.
  always_comb begin
    state_next = state_reg;
    state_next.rsp.ack = i_req.valid;
    state_next.rsp.err = i_req.valid && !access_ok;
    state_next.rsp.rdata = '0;
    state_next.wr = cell_we;
    // Refused and write accesses return zero data
    if (i_req.valid && !i_req.we && access_ok) begin
      state_next.rsp.rdata[SRA_BYTE_W-1:0] = rd_value[lo_idx];
      if (i_req.wide) begin
        state_next.rsp.rdata[SRA_WORD_W-1:SRA_BYTE_W] = rd_value[hi_idx];
      end
    end
    if (load_init) begin
      state_next = '0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    state_reg <= state_next;
  end

  assign o_rsp = state_reg.rsp;
  assign o_wr_pulse = state_reg.wr;

endmodule : sra_area

// ---- test/sra_area_checker.sv ----
// Port checks of the special register area
`timescale 1ns/1ps
module sra_area_checker
  import sra_pkg::*;
#(
  parameter int SLOTS = SRA_SLOTS
) (
  input wire logic i_sys_clk,  // Clock
  input wire logic i_rst,  // Reset
  input wire sra_pkg::sra_init_s i_init,  // Load causes
  input wire sra_pkg::sra_req_s i_req,  // Request
  input wire logic [SLOTS-1:0][7:0] i_hw_value,  // RO sources
  input wire sra_pkg::sra_rsp_s o_rsp,  // Answer
  input wire logic [SLOTS-1:0][7:0] o_value,  // Stored bytes
  input wire logic [SLOTS-1:0] o_wr_pulse  // Write pulses
);
  logic take;
  assign take = i_req.valid && !i_rst && !(|i_init);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  AST_ACK: assert property (take |=> o_rsp.ack)
    else $error("no answer");
  AST_INIT: assert property ((|i_init) |=> !o_rsp.ack &&
    o_value[0] == 8'hff && o_value[4] == 8'h8b) else $error("no init");
  AST_W8: assert property (take && i_req.wide &&
    i_req.addr[7:2] == 6'h04 |=> o_rsp.err) else $error("wide taken");
  AST_RO_WR: assert property (take && i_req.we &&
    i_req.addr == 8'h12 |=> o_rsp.err && !o_wr_pulse[6])
    else $error("read-only written");
  AST_WR: assert property (take && i_req.we && !i_req.wide &&
    i_req.addr == 8'h02 |=> o_wr_pulse[2] &&
    o_value[2] == $past(i_req.wdata[7:0])) else $error("write lost");
  AST_FIX0: assert property (o_value[3][7:4] == 4'h0)
    else $error("fixed zero set");
  AST_FIX1: assert property (o_value[7][3:2] == 2'b11)
    else $error("fixed one clear");
  AST_IGN: assert property ((o_value[4] & 8'hf8) == 8'h88)
    else $error("ignored bits moved");
  cover property (take && i_req.wide);
  cover property (o_rsp.err);
  cover property (|i_init);
endmodule : sra_area_checker

bind sra_area sra_area_checker #(.SLOTS(SLOTS)) i_sra_area_checker (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_init(i_init), .i_req(i_req),
  .i_hw_value(i_hw_value), .o_rsp(o_rsp), .o_value(o_value),
  .o_wr_pulse(o_wr_pulse));

// ---- test/sra_cpu_model.sv ----
// CPU core model issuing data memory accesses
`timescale 1ns/1ps
module sra_cpu_model
  import sra_pkg::*;
(
  input wire logic i_sys_clk,  // Clock
  output sra_pkg::sra_req_s o_req,  // Request
  input wire sra_pkg::sra_rsp_s i_rsp  // Answer
);
  initial o_req = '{1'b0, 1'b0, 1'b0, 8'h5a, 16'ha5a5};
  // Callers pick unit and direction; undefined bits are never compared
  task automatic access(input logic we, wide, input logic [7:0] a,
      input logic [15:0] wd, output sra_pkg::sra_rsp_s r);
    @(negedge i_sys_clk);
    o_req <= '{1'b1, we, wide, a, wd};
    @(negedge i_sys_clk);
    r = i_rsp;
    // Released lines flip so a stale request never looks valid
    o_req <= '{1'b0, ~we, ~wide, ~a, ~wd};
  endtask : access
endmodule : sra_cpu_model

// ---- test/sra_area_test.sv ----
// Self-checking bench of the special register area
`timescale 1ns/1ps
module sra_area_test;
  import sra_pkg::*;
  localparam logic [1:0] OK = 2'b10;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  sra_init_s i_init = '0;
  sra_req_s req;
  sra_rsp_s rsp;
  logic [SRA_SLOTS-1:0][7:0] hw = '0;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  sra_area i_sra_area (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_init(i_init),
    .i_req(req), .i_hw_value(hw), .o_rsp(rsp), .o_value(), .o_wr_pulse());
  sra_cpu_model i_sra_cpu_model (.i_sys_clk(i_sys_clk), .o_req(req),
    .i_rsp(rsp));
  initial forever #4 i_sys_clk = ~i_sys_clk;
  task automatic complete_run();
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      complete_run();
    end
  end
  // Answer seen as {ack, err, rdata}
  task automatic xfer(input logic we, wide, input logic [7:0] a,
      input logic [15:0] wd, input logic [17:0] exp);
    sra_rsp_s r;
    i_sra_cpu_model.access(we, wide, a, wd, r);
    checks++;
    if (r !== exp) begin
      error_cnt++;
      $display("unexpected answer at %h exp %h got %h", a, exp, r);
    end
  endtask : xfer
  task automatic t_rw();
    xfer(0, 1, 8'h00, 0, {OK, 16'hffff});
    xfer(0, 0, 8'h10, 0, {OK, 16'h008b});
    xfer(1, 0, 8'h02, 16'h00a5, {OK, 16'h0});
    xfer(0, 0, 8'h02, 0, {OK, 16'h00a5});
    xfer(1, 1, 8'h03, 16'h0b3c, {OK, 16'h0});
    xfer(0, 1, 8'h02, 0, {OK, 16'h0b3c});
    xfer(0, 0, 8'h03, 0, {OK, 16'h000b});
    hw[6] = 8'h5e;
    xfer(0, 0, 8'h12, 0, {OK, 16'h005e});
  endtask : t_rw
  task automatic t_bits();
    xfer(1, 0, 8'h13, 16'h000d, {OK, 16'h0});
    xfer(0, 0, 8'h13, 0, {OK, 16'h000d});
    xfer(1, 0, 8'h10, 16'h00ff, {OK, 16'h0});
    xfer(0, 0, 8'h10, 0, {OK, 16'h008f});
    xfer(1, 0, 8'h10, 16'h0000, {OK, 16'h0});
    xfer(0, 0, 8'h10, 0, {OK, 16'h0088});
  endtask : t_bits
  // Wrong unit, direction or place: each is refused
  task automatic t_refuse();
    logic [9:0] tab [5] = '{10'h000, 10'h110, 10'h212, 10'h011, 10'h020};
    foreach (tab[k]) begin
      xfer(tab[k][9], tab[k][8], tab[k][7:0], 0, {2'b11, 16'h0});
    end
  endtask : t_refuse
  task automatic t_causes();
    for (int k = 0; k < 4; k++) begin
      xfer(1, 0, 8'h02, 16'h0077, {OK, 16'h0});
      i_init = sra_init_s'(4'h1 << k);
      @(negedge i_sys_clk);
      i_init = '0;
      xfer(0, 0, 8'h02, 0, {OK, 16'h0000});
    end
  endtask : t_causes
  initial begin
    repeat (10) @(negedge i_sys_clk);
    i_rst = 1'b0;
    t_rw();
    t_bits();
    t_refuse();
    t_causes();
    complete_run();
  end
endmodule : sra_area_test
